/* File: rtl/cpu_state_pkg.sv */
// Shared constants, command codes and vector lookup for the CPU state block.
package cpu_state_pkg;

  // Program memory size and interrupt source count.
  localparam int PROG_BYTES_DEF = 2048;
  localparam int NUM_IRQ        = 7;
  localparam int IRQ_IDX_W      = 3;

  // Fixed program memory locations of the two-byte vectors and the page call area base.
  localparam logic [15:0] RESET_VEC  = 16'hfffe;
  localparam logic [15:0] TBCALL_BASE = 16'hffde;
  localparam logic [15:0] BREAK_VEC   = TBCALL_BASE;
  localparam logic [15:0] PGCALL_BASE = 16'hff00;
  localparam logic [15:0] VEC_EXT0   = 16'hfffa;
  localparam logic [15:0] VEC_EXT1   = 16'hfff8;
  localparam logic [15:0] VEC_TMR0   = 16'hfff6;
  localparam logic [15:0] VEC_TMR1   = 16'hfff4;
  localparam logic [15:0] VEC_ADC    = 16'hffea;
  localparam logic [15:0] VEC_WDT    = 16'hffe8;
  localparam logic [15:0] VEC_ITIMER = 16'hffe6;

  // Status word bit positions.
  localparam int FLAG_C   = 0;
  localparam int FLAG_Z   = 1;
  localparam int FLAG_I   = 2;
  localparam int FLAG_H   = 3;
  localparam int FLAG_B   = 4;
  localparam int FLAG_V   = 6;
  localparam int FLAG_N   = 7;
  localparam int SIGN_BIT = 7;

  // Reset values of the control state.
  localparam logic [7:0] STW_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Interrupt source indices; a lower index has the higher priority.
  localparam logic [2:0] IRQ_EXT0   = 3'h0;
  localparam logic [2:0] IRQ_EXT1   = 3'h1;
  localparam logic [2:0] IRQ_TMR0   = 3'h2;
  localparam logic [2:0] IRQ_TMR1   = 3'h3;
  localparam logic [2:0] IRQ_ADC    = 3'h4;
  localparam logic [2:0] IRQ_WDT    = 3'h5;
  localparam logic [2:0] IRQ_ITIMER = 3'h6;

  // Commands that the instruction sequencer hands to this block.
  typedef enum logic [5:0] {
    CMD_NOP, CMD_FETCH, CMD_ADC, CMD_SBC, CMD_CMPX, CMD_CMPY,
    CMD_LDA, CMD_LDX, CMD_LDY, CMD_LDYA, CMD_TAX, CMD_TXA, CMD_TAY, CMD_TYA,
    CMD_INCX, CMD_DECX, CMD_INCY, CMD_DECY, CMD_ASL, CMD_ROR, CMD_BIT,
    CMD_IEN, CMD_IDS, CMD_VCLR, CMD_TXSP, CMD_IDXX, CMD_IDXY,
    CMD_CALL, CMD_PGCALL, CMD_TBCALL, CMD_BREAK, CMD_RSUB, CMD_RINT
  } cmd_t;

  // Vector address of an interrupt source.
  function automatic logic [15:0] irq_vector(input logic [2:0] src);
    case (src)
      IRQ_EXT0:   return VEC_EXT0;
      IRQ_EXT1:   return VEC_EXT1;
      IRQ_TMR0:   return VEC_TMR0;
      IRQ_TMR1:   return VEC_TMR1;
      IRQ_ADC:    return VEC_ADC;
      IRQ_WDT:    return VEC_WDT;
      default:    return VEC_ITIMER;
    endcase
  endfunction

endpackage

/* File: rtl/alu_if.sv */
// Operand and flag carrier between the state core and its adder.
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic       sub;
  logic [7:0] sum;
  logic       cout;
  logic       half;
  logic       ovf;
  modport core (output a, b, cin, sub, input sum, cout, half, ovf);
  modport unit (input a, b, cin, sub, output sum, cout, half, ovf);
endinterface
`default_nettype wire

/* File: rtl/alu_adder.sv */
// Eight-bit add and subtract unit producing carry, half carry and overflow.
`timescale 1ns/100ps
`default_nettype none
module alu_adder
(
  alu_if.unit bus
);
  logic [7:0] b_eff;
  logic [8:0] full;
  logic [4:0] low;

  // Subtraction adds the inverted operand; carry then means no borrow.
  always_comb
  begin
    b_eff = bus.sub ? ~bus.b : bus.b;
    full  = {1'b0, bus.a} + {1'b0, b_eff} + {8'h00, bus.cin};
    low   = {1'b0, bus.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, bus.cin};
  end

  // Signed overflow appears when equal-signed inputs give a result of the other sign.
  assign bus.sum  = full[7:0];
  assign bus.cout = full[8];
  assign bus.half = low[4];
  assign bus.ovf  = (bus.a[7] == b_eff[7]) && (full[7] != bus.a[7]);
endmodule
`default_nettype wire

/* File: rtl/cpu_state.sv */
// Programmer-visible CPU state: registers, status word, stack and vector sequencing.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// (R01) Program counter is 16 bits, built from high and low byte halves.
// (R02) After reset the program counter loads from the vector at FFFE and FFFF.
// (R03) Accumulator pairs with Y to form one 16-bit word register.
// (R04) Indexed address adds X or Y; index registers increment, decrement, compare, transfer.
// (R05) Stack pointer is not reset; software must load it before calls.
// (R06) Stack lives in data memory 00 to 7F; calls and interrupts update it.
// (R07) Stack pointer decrements after each save, increments before each restore.
// (R08) Subroutine return restores the counter; interrupt return also restores status.
// (R09) Carry takes arithmetic carry or borrow and shift or rotate output.
// (R10) Zero flag is set on a zero result, cleared otherwise.
// (R11) With interrupt enable clear, only reset and software break get through.
// (R12) Servicing an interrupt clears enable; enable and disable commands set and clear.
// (R13) Half carry follows bit 3 carry; clear-overflow clears it with overflow.
// (R14) Software break sets the break flag to tell it from table call 0.
// (R15) Overflow flags signed results beyond +127 or -128; clear-overflow clears it, add, subtract, bit test and interrupt return also rewrite it.
// (R16) Bit test copies operand bit 6 to overflow and bit 7 to negative.
// (R17) Negative flag equals bit 7 of each data or arithmetic result.
// (R18) Program memory is read only, 2K present, fetch address wraps past FFFF.
// (R19) Table call n vectors through FFDE minus twice n, down to FFC0.
// (R20) Software break uses the table call 0 vector.
// (R21) External interrupt 1 vectors through FFF8, external interrupt 0 through FFFA.
// (R22) Internal sources use FFE6, FFE8, FFEA, FFF4 and FFF6.
// (R23) Page call reaches subroutines in the page call area.
// (R24) Configuration area is reachable only in program and verify mode.
// (R25) Unused vector slots are ordinary program memory.
// (R26) Vectors are read low byte at even address, then high byte.
// (R27) Interrupt acceptance pushes return counter and status before loading vector.
module cpu_state
  import cpu_state_pkg::*;
#(
  parameter int PROG_BYTES = PROG_BYTES_DEF,
  parameter int PROG_AW    = $clog2(PROG_BYTES)
)(
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 cmd_valid,
  input  wire cmd_t                 cmd,
  input  wire logic [7:0]           cmd_operand,
  input  wire logic [15:0]          cmd_addr,
  output logic                      cmd_ready,
  input  wire logic [7:0]           prog_rdata,
  output logic [15:0]               prog_addr,
  output logic [PROG_AW-1:0]        prog_phys_addr,
  output logic                      prog_rd,
  input  wire logic [7:0]           data_rdata,
  output logic [7:0]                data_addr,
  output logic [7:0]                data_wdata,
  output logic                      data_wr,
  output logic                      data_rd,
  input  wire logic [NUM_IRQ-1:0]   irq_req,
  output logic                      irq_ack,
  output logic [IRQ_IDX_W-1:0]      irq_ack_src,
  input  wire logic                 prog_mode,
  input  wire logic                 cfg_req,
  output logic                      cfg_grant,
  output logic [7:0]                pc_high_byte,
  output logic [7:0]                pc_low_byte,
  output logic [7:0]                accumulator,
  output logic [7:0]                x_index,
  output logic [7:0]                y_index,
  output logic [15:0]               pair_word_register,
  output logic [7:0]                stack_pointer,
  output logic [7:0]                status_word,
  output logic [15:0]               index_addr
);
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_STW, ST_VEC_LO, ST_VEC_HI,
    ST_VEC_END, ST_POP_STW, ST_POP_LO, ST_POP_HI, ST_POP_END
  } state_t;

  state_t        state_r, state_nxt;
  logic [15:0]   pc_r, vec_r, target_r;
  logic [7:0]    a_r, x_r, y_r, stk_r, stw_r, stw_save_r, vec_lo_r, res;
  logic          push_stw_r, use_vec_r, pop_stw_r, ready_r, i_nxt;
  logic [NUM_IRQ-1:0] irq_s1_r, irq_s2_r;
  logic          irq_pend_r, mode_s1_r, mode_s2_r;
  logic [IRQ_IDX_W-1:0] irq_src_r, irq_pick;
  logic          take_cmd, take_irq;
  alu_if         alu_bus ();

  alu_adder u_alu (.bus(alu_bus.unit));

  // Accepted work: a command needs ready; an interrupt needs the enable flag.
  assign take_cmd = cmd_valid && ready_r;
  assign take_irq = (state_r == ST_IDLE) && stw_r[FLAG_I] && irq_pend_r; // R11

  // Adder operands: accumulator or index register against the command operand.
  always_comb
  begin
    alu_bus.a   = a_r;
    alu_bus.b   = cmd_operand;
    alu_bus.cin = stw_r[FLAG_C];
    alu_bus.sub = (cmd == CMD_SBC) || (cmd == CMD_CMPX) || (cmd == CMD_CMPY);
    if (cmd == CMD_CMPX || cmd == CMD_CMPY)
    begin
      alu_bus.a   = (cmd == CMD_CMPX) ? x_r : y_r; // R04
      alu_bus.cin = 1'b1;
    end
  end

  // Result of loads, transfers, steps and shifts.
  always_comb
  begin
    case (cmd)
      CMD_TAX, CMD_TAY: res = a_r;
      CMD_TXA:          res = x_r;
      CMD_TYA:          res = y_r;
      CMD_INCX:         res = x_r + 8'h01; // R04
      CMD_DECX:         res = x_r - 8'h01;
      CMD_INCY:         res = y_r + 8'h01;
      CMD_DECY:         res = y_r - 8'h01;
      CMD_ASL:          res = {a_r[6:0], 1'b0};
      CMD_ROR:          res = {stw_r[FLAG_C], a_r[7:1]};
      default:          res = cmd_operand;
    endcase
  end

  // Interrupt enable next value, shared by the flag and the ready logic.
  always_comb
  begin
    i_nxt = stw_r[FLAG_I];
    if (take_irq)
      i_nxt = 1'b0; // R12
    else if (take_cmd && cmd == CMD_IEN)
      i_nxt = 1'b1; // R12
    else if (take_cmd && cmd == CMD_IDS)
      i_nxt = 1'b0; // R12
    else if (state_r == ST_POP_LO && pop_stw_r)
      i_nxt = data_rdata[FLAG_I];
  end

  // Highest-priority pending source: lowest index wins.
  always_comb
  begin
    irq_pick = IRQ_ITIMER;
    for (int k = NUM_IRQ - 1; k >= 0; k--)
      if (irq_s2_r[k])
        irq_pick = IRQ_IDX_W'(k);
  end

  // Sequencer next state.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET:    state_nxt = ST_VEC_LO; // R02
      ST_IDLE:
        if (take_irq)
          state_nxt = ST_PUSH_HI; // R27
        else if (take_cmd)
        begin
          case (cmd)
            CMD_CALL, CMD_PGCALL, CMD_TBCALL, CMD_BREAK: state_nxt = ST_PUSH_HI;
            CMD_RSUB: state_nxt = ST_POP_LO; // R08
            CMD_RINT: state_nxt = ST_POP_STW; // R08
            default:  state_nxt = ST_IDLE;
          endcase
        end
      ST_PUSH_HI:  state_nxt = ST_PUSH_LO;
      ST_PUSH_LO:  state_nxt = push_stw_r ? ST_PUSH_STW : (use_vec_r ? ST_VEC_LO : ST_IDLE);
      ST_PUSH_STW: state_nxt = ST_VEC_LO;
      ST_VEC_LO:   state_nxt = ST_VEC_HI;
      ST_VEC_HI:   state_nxt = ST_VEC_END;
      ST_POP_STW:  state_nxt = ST_POP_LO;
      ST_POP_LO:   state_nxt = ST_POP_HI;
      ST_POP_HI:   state_nxt = ST_POP_END;
      default:     state_nxt = ST_IDLE;
    endcase
  end

  // State register and ready, which is low whenever an interrupt will win next.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_RESET;
      ready_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == ST_IDLE) && !(i_nxt && (|irq_s2_r));
    end
  end

  // Per-transfer context latched when work is accepted.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vec_r      <= RESET_VEC; // R02
      target_r   <= 16'h0000;
      push_stw_r <= 1'b0;
      use_vec_r  <= 1'b0;
      pop_stw_r  <= 1'b0;
      stw_save_r <= STW_RESET;
    end
    else if (take_irq)
    begin
      vec_r      <= irq_vector(irq_src_r); // R21 R22
      push_stw_r <= 1'b1; // R27
      use_vec_r  <= 1'b1;
      stw_save_r <= stw_r;
    end
    else if (take_cmd)
    begin
      push_stw_r <= (cmd == CMD_BREAK);
      use_vec_r  <= (cmd == CMD_TBCALL) || (cmd == CMD_BREAK);
      pop_stw_r  <= (cmd == CMD_RINT); // R08
      stw_save_r <= stw_r | (8'h01 << FLAG_B); // R14
      target_r   <= (cmd == CMD_PGCALL) ? (PGCALL_BASE | {8'h00, cmd_operand}) : cmd_addr; // R23
      if (cmd == CMD_BREAK)
        vec_r <= BREAK_VEC; // R20
      else
        vec_r <= TBCALL_BASE - {11'h000, cmd_operand[3:0], 1'b0}; // R19
    end
  end

  // Program counter: fetch step, call target, vector load and stack restore.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_r     <= 16'h0000;
      vec_lo_r <= REG_RESET;
    end
    else
    begin
      if (take_cmd && cmd == CMD_FETCH)
        pc_r <= pc_r + 16'h0001; // R18
      if (state_r == ST_PUSH_LO && !push_stw_r && !use_vec_r)
        pc_r <= target_r; // R23
      if (state_r == ST_VEC_HI)
        vec_lo_r <= prog_rdata; // R26
      if (state_r == ST_VEC_END)
        pc_r <= {prog_rdata, vec_lo_r}; // R01 R26
      if (state_r == ST_POP_HI)
        pc_r[7:0] <= data_rdata; // R08
      if (state_r == ST_POP_END)
        pc_r[15:8] <= data_rdata; // R08
    end
  end

  // Program memory reads happen only for vectors; there is no write path.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prog_addr      <= 16'h0000;
      prog_phys_addr <= '0;
      prog_rd        <= 1'b0;
    end
    else
    begin
      prog_rd <= (state_r == ST_VEC_LO) || (state_r == ST_VEC_HI); // R25
      if (state_r == ST_VEC_LO)
      begin
        prog_addr      <= vec_r; // R26
        prog_phys_addr <= vec_r[PROG_AW-1:0]; // R18
      end
      else if (state_r == ST_VEC_HI)
      begin
        prog_addr      <= vec_r + 16'h0001; // R26
        prog_phys_addr <= PROG_AW'(vec_r + 16'h0001);
      end
    end
  end

  // Accumulator and index registers.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      a_r        <= REG_RESET;
      x_r        <= REG_RESET;
      y_r        <= REG_RESET;
      index_addr <= 16'h0000;
    end
    else if (take_cmd)
    begin
      case (cmd)
        CMD_ADC, CMD_SBC:                     a_r <= alu_bus.sum;
        CMD_LDA, CMD_TXA, CMD_TYA, CMD_ASL, CMD_ROR: a_r <= res;
        CMD_LDX, CMD_TAX, CMD_INCX, CMD_DECX: x_r <= res; // R04
        CMD_LDY, CMD_TAY, CMD_INCY, CMD_DECY: y_r <= res; // R04
        CMD_LDYA:
        begin
          y_r <= cmd_addr[15:8]; // R03
          a_r <= cmd_addr[7:0]; // R03
        end
        CMD_IDXX: index_addr <= cmd_addr + {8'h00, x_r}; // R04
        CMD_IDXY: index_addr <= cmd_addr + {8'h00, y_r}; // R04
        default: ;
      endcase
    end
  end

  // Status word flags.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      stw_r <= STW_RESET;
    else
    begin
      stw_r[FLAG_I] <= i_nxt;
      if (state_r == ST_POP_LO && pop_stw_r)
        stw_r <= data_rdata; // R08
      else if (take_cmd)
      begin
        case (cmd)
          CMD_ADC, CMD_SBC:
          begin
            stw_r[FLAG_C] <= alu_bus.cout; // R09
            stw_r[FLAG_H] <= alu_bus.half; // R13
            stw_r[FLAG_V] <= alu_bus.ovf; // R15
            stw_r[FLAG_N] <= alu_bus.sum[SIGN_BIT]; // R17
            stw_r[FLAG_Z] <= (alu_bus.sum == 8'h00); // R10
          end
          CMD_CMPX, CMD_CMPY:
          begin
            stw_r[FLAG_C] <= alu_bus.cout; // R09
            stw_r[FLAG_N] <= alu_bus.sum[SIGN_BIT];
            stw_r[FLAG_Z] <= (alu_bus.sum == 8'h00);
          end
          CMD_ASL, CMD_ROR:
          begin
            stw_r[FLAG_C] <= (cmd == CMD_ASL) ? a_r[SIGN_BIT] : a_r[0]; // R09
            stw_r[FLAG_N] <= res[SIGN_BIT];
            stw_r[FLAG_Z] <= (res == 8'h00);
          end
          CMD_LDA, CMD_LDX, CMD_LDY, CMD_TAX, CMD_TXA, CMD_TAY, CMD_TYA,
          CMD_INCX, CMD_DECX, CMD_INCY, CMD_DECY:
          begin
            stw_r[FLAG_N] <= res[SIGN_BIT]; // R17
            stw_r[FLAG_Z] <= (res == 8'h00); // R10
          end
          CMD_LDYA:
          begin
            stw_r[FLAG_N] <= cmd_addr[15]; // R03
            stw_r[FLAG_Z] <= (cmd_addr == 16'h0000);
          end
          CMD_BIT:
          begin
            stw_r[FLAG_V] <= cmd_operand[FLAG_V]; // R16
            stw_r[FLAG_N] <= cmd_operand[FLAG_N]; // R16
            stw_r[FLAG_Z] <= ((a_r & cmd_operand) == 8'h00);
          end
          CMD_VCLR:
          begin
            stw_r[FLAG_V] <= 1'b0; // R15
            stw_r[FLAG_H] <= 1'b0; // R13
          end
          CMD_BREAK: stw_r[FLAG_B] <= 1'b1; // R14
          default: ;
        endcase
      end
    end
  end

  // Stack pointer: deliberately without reset, software must load it first.
  always_ff @(posedge clk_sys)
  begin
    if (take_cmd && cmd == CMD_TXSP)
      stk_r <= x_r; // R05
    else if (state_r == ST_PUSH_HI || state_r == ST_PUSH_LO || state_r == ST_PUSH_STW)
      stk_r <= stk_r - 8'h01; // R06 R07
    else if (state_r == ST_POP_STW || state_r == ST_POP_LO || state_r == ST_POP_HI)
      stk_r <= stk_r + 8'h01; // R06 R07
  end

  // Stack traffic: save at the pointer, restore from the pointer plus one.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_addr  <= 8'h00;
      data_wdata <= 8'h00;
      data_wr    <= 1'b0;
      data_rd    <= 1'b0;
    end
    else
    begin
      data_wr <= 1'b0;
      data_rd <= 1'b0;
      case (state_r)
        ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_STW:
        begin
          data_addr <= stk_r; // R07
          data_wr   <= 1'b1;
          data_wdata <= (state_r == ST_PUSH_HI) ? pc_r[15:8] :
                        (state_r == ST_PUSH_LO) ? pc_r[7:0] : stw_save_r; // R27
        end
        ST_POP_STW, ST_POP_LO, ST_POP_HI:
        begin
          data_addr <= stk_r + 8'h01; // R07
          data_rd   <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Pin synchronisers, interrupt pending state and acknowledge.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_s1_r    <= '0;
      irq_s2_r    <= '0;
      mode_s1_r   <= 1'b0;
      mode_s2_r   <= 1'b0;
      irq_pend_r  <= 1'b0;
      irq_src_r   <= IRQ_EXT0;
      irq_ack     <= 1'b0;
      irq_ack_src <= IRQ_EXT0;
      cfg_grant   <= 1'b0;
    end
    else
    begin
      irq_s1_r   <= irq_req;
      irq_s2_r   <= irq_s1_r;
      mode_s1_r  <= prog_mode;
      mode_s2_r  <= mode_s1_r;
      irq_pend_r <= |irq_s2_r;
      irq_src_r  <= irq_pick;
      irq_ack    <= take_irq; // R12
      if (take_irq)
        irq_ack_src <= irq_src_r;
      cfg_grant  <= cfg_req && mode_s2_r; // R24
    end
  end

  assign cmd_ready          = ready_r;
  assign pc_high_byte       = pc_r[15:8];
  assign pc_low_byte        = pc_r[7:0];
  assign accumulator        = a_r;
  assign x_index            = x_r;
  assign y_index            = y_r;
  assign pair_word_register = {y_r, a_r};
  assign stack_pointer      = stk_r;
  assign status_word        = stw_r;

  // Checks next to the logic above.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  reset_vector_a: assert property ( // R02
    (state_r == ST_RESET) |=> ##1 (prog_rd && prog_addr == RESET_VEC))
    else $error("reset vector low byte not read first");
  vector_pair_a: assert property ( // R26
    (state_r == ST_VEC_END) |=> (pc_r == {$past(prog_rdata), $past(vec_lo_r)}))
    else $error("vector not loaded low then high");
  irq_masked_a: assert property ( // R11
    irq_ack |-> $past(stw_r[FLAG_I]))
    else $error("interrupt taken while disabled");
  irq_clears_i_a: assert property ( // R12
    irq_ack |-> !stw_r[FLAG_I] && state_r == ST_PUSH_HI)
    else $error("enable not cleared on service");
  push_post_dec_a: assert property ( // R07
    data_wr |-> (stk_r == data_addr - 8'h01))
    else $error("pointer not decremented after save");
  bit_copy_a: assert property ( // R16
    (take_cmd && cmd == CMD_BIT) |=>
      (stw_r[FLAG_V] == $past(cmd_operand[FLAG_V]) && stw_r[FLAG_N] == $past(cmd_operand[FLAG_N])))
    else $error("bit test flags wrong");
  zero_load_a: assert property ( // R10
    (take_cmd && cmd == CMD_LDA) |=> (stw_r[FLAG_Z] == ($past(cmd_operand) == 8'h00)))
    else $error("zero flag wrong after load");
  clear_ovf_a: assert property ( // R13
    (take_cmd && cmd == CMD_VCLR) |=> (!stw_r[FLAG_V] && !stw_r[FLAG_H]))
    else $error("clear overflow left a flag set");
  table_call_instr_vec_a: assert property ( // R19
    (take_cmd && cmd == CMD_TBCALL) |=> ##3
      (prog_addr == TBCALL_BASE - {11'h000, $past(cmd_operand[3:0], 4), 1'b0}))
    else $error("table call vector address wrong");
  cfg_block_a: assert property ( // R24
    cfg_grant |-> $past(mode_s2_r))
    else $error("configuration access outside program mode");
  pc_wrap_a: assert property ( // R18
    (take_cmd && cmd == CMD_FETCH && pc_r == 16'hffff) |=> (pc_r == 16'h0000))
    else $error("program counter did not wrap");
endmodule
`default_nettype wire

/* File: tb/cpu_state_test.sv */
// Self-checking bench for the CPU state block, driven through its command port.
`timescale 1ns/100ps
`default_nettype none
module cpu_state_test;
  import cpu_state_pkg::*;
  logic               clk_sys     = 1'b0;
  logic               reset_n     = 1'b0;
  logic               cmd_valid   = 1'b0;
  cmd_t               cmd         = CMD_NOP;
  logic [7:0]         cmd_operand = 8'h00;
  logic [15:0]        cmd_addr    = 16'h0000;
  logic [NUM_IRQ-1:0] irq_req     = '0;
  logic               prog_mode   = 1'b0;
  logic               cfg_req     = 1'b0;
  logic               cmd_ready, prog_rd, data_wr, data_rd, irq_ack, cfg_grant;
  logic [15:0]        prog_addr, pair_word_register, index_addr;
  logic [10:0]        prog_phys_addr;
  logic [7:0]         prog_rdata, data_rdata, data_addr, data_wdata;
  logic [7:0]         pc_high_byte, pc_low_byte, accumulator, x_index, y_index;
  logic [7:0]         stack_pointer, status_word;
  logic [2:0]         irq_ack_src;
  logic [7:0]         dmem [256];
  logic [15:0]        vec [7] = '{16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hffea,
                                  16'hffe8, 16'hffe6};
  int                 bad_count   = 0;
  int                 comparisons = 0;
  int                 n;
  // Clock at 8 ns period.
  always #4 clk_sys = ~clk_sys;
  // Program memory returns a byte derived from its address.
  function automatic logic [7:0] pm(input logic [15:0] a);
    return a[7:0] + 8'h11;
  endfunction
  function automatic logic [15:0] vexp(input logic [15:0] a);
    return {pm(a + 16'h0001), pm(a)};
  endfunction
  assign prog_rdata = pm(prog_addr);
  assign data_rdata = dmem[data_addr];
  // Stack memory stores the block's writes.
  always @(posedge clk_sys)
    if (data_wr === 1'b1)
      dmem[data_addr] <= data_wdata;
  cpu_state u_dut (.clk_sys, .reset_n, .cmd_valid, .cmd, .cmd_operand, .cmd_addr,
    .cmd_ready, .prog_rdata, .prog_addr, .prog_phys_addr, .prog_rd, .data_rdata,
    .data_addr, .data_wdata, .data_wr, .data_rd, .irq_req, .irq_ack, .irq_ack_src,
    .prog_mode, .cfg_req, .cfg_grant, .pc_high_byte, .pc_low_byte, .accumulator,
    .x_index, .y_index, .pair_word_register, .stack_pointer, .status_word, .index_addr);
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    print_verdict();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits until the block accepts commands again.
  task automatic idle();
    int i;
    repeat (2) @(negedge clk_sys);
    for (i = 0; i < 60 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 60) give_up();
  endtask
  // Offers one command and holds it until the edge that takes it.
  task automatic offer(input cmd_t c, input logic [7:0] op, input logic [15:0] ad);
    int i;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_operand <= op;
    cmd_addr <= ad;
    @(negedge clk_sys);
    for (i = 0; i < 60 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 60) give_up();
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask
  task automatic issue(input cmd_t c, input logic [7:0] op, input logic [15:0] ad);
    offer(c, op, ad);
    idle();
  endtask
  task automatic wait_ack();
    int i;
    for (i = 0; i < 60 && irq_ack !== 1'b1; i++) @(negedge clk_sys);
    if (i == 60) give_up();
  endtask
  // Main sequence of scenarios.
  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    idle();
    chk(16'(status_word), 16'h0000);
    chk({pc_high_byte, pc_low_byte}, vexp(16'hfffe));
    chk(16'(prog_phys_addr), 16'h07ff);
    issue(CMD_LDX, 8'h7f, 16'h0000);
    issue(CMD_TXSP, 8'h00, 16'h0000);
    chk(16'(stack_pointer), 16'h007f);
    issue(CMD_LDA, 8'h00, 16'h0000);
    chk(16'(status_word & 8'h82), 16'h0002);
    issue(CMD_LDA, 8'h7f, 16'h0000);
    issue(CMD_ADC, 8'h01, 16'h0000);
    chk(16'(status_word & 8'hcb), 16'h00c8);
    issue(CMD_ADC, 8'h80, 16'h0000);
    chk(16'(status_word & 8'hcb), 16'h0043);
    issue(CMD_VCLR, 8'h00, 16'h0000);
    chk(16'(status_word & 8'h48), 16'h0000);
    issue(CMD_BIT, 8'hc0, 16'h0000);
    chk(16'(status_word & 8'hc0), 16'h00c0);
    issue(CMD_LDA, 8'h81, 16'h0000);
    issue(CMD_ASL, 8'h00, 16'h0000);
    chk({accumulator, 8'(status_word & 8'h83)}, 16'h0201);
    issue(CMD_ROR, 8'h00, 16'h0000);
    chk({accumulator, 8'(status_word & 8'h83)}, 16'h8180);
    issue(CMD_SBC, 8'h01, 16'h0000);
    chk({accumulator, 8'(status_word & 8'hc3)}, 16'h7f41);
    issue(CMD_CMPX, 8'h7f, 16'h0000);
    chk(16'(status_word & 8'h83), 16'h0003);
    issue(CMD_LDYA, 8'h00, 16'h1234);
    chk(pair_word_register, 16'h1234);
    issue(CMD_LDX, 8'hff, 16'h0000);
    issue(CMD_INCX, 8'h00, 16'h0000);
    chk(16'(x_index), 16'h0000);
    issue(CMD_LDX, 8'h05, 16'h0000);
    issue(CMD_IDXX, 8'h00, 16'h10fe);
    chk(index_addr, 16'h1103);
    issue(CMD_CALL, 8'h00, 16'h2345);
    chk({pc_high_byte, pc_low_byte}, 16'h2345);
    chk({stack_pointer, dmem[8'h7f]}, {8'h7d, pm(16'hffff)});
    issue(CMD_RSUB, 8'h00, 16'h0000);
    chk({stack_pointer, pc_high_byte, pc_low_byte} & 24'hffffff, {8'h7f, vexp(16'hfffe)});
    issue(CMD_PGCALL, 8'h35, 16'h0000);
    chk({pc_high_byte, pc_low_byte}, 16'hff35);
    issue(CMD_RSUB, 8'h00, 16'h0000);
    issue(CMD_CALL, 8'h00, 16'hffff);
    issue(CMD_FETCH, 8'h00, 16'h0000);
    chk({pc_high_byte, pc_low_byte}, 16'h0000);
    issue(CMD_RSUB, 8'h00, 16'h0000);
    // Every table call number, then return.
    for (n = 0; n < 16; n++)
    begin
      issue(CMD_TBCALL, 8'(n), 16'h0000);
      chk({pc_high_byte, pc_low_byte}, vexp(16'hffde - 16'(2 * n)));
      issue(CMD_RSUB, 8'h00, 16'h0000);
    end
    issue(CMD_BREAK, 8'h00, 16'h0000);
    chk({pc_high_byte, pc_low_byte}, vexp(16'hffde));
    chk(16'(status_word & 8'h10), 16'h0010);
    issue(CMD_RINT, 8'h00, 16'h0000);
    chk(16'(stack_pointer), 16'h007f);
    // A request while disabled is not taken.
    @(posedge clk_sys);
    irq_req[0] <= 1'b1;
    repeat (12) @(negedge clk_sys) chk(16'(irq_ack), 16'h0000);
    offer(CMD_IEN, 8'h00, 16'h0000);
    for (n = 0; n < NUM_IRQ; n++)
    begin
      @(posedge clk_sys);
      irq_req[n] <= 1'b1;
      wait_ack();
      @(posedge clk_sys);
      irq_req <= '0;
      idle();
      chk(16'(irq_ack_src), 16'(n));
      chk({pc_high_byte, pc_low_byte}, vexp(vec[n]));
      chk(16'(status_word & 8'h04), 16'h0000);
      issue(CMD_RINT, 8'h00, 16'h0000);
      chk(16'(status_word & 8'h04), 16'h0004);
    end
    issue(CMD_IDS, 8'h00, 16'h0000);
    chk(16'(status_word & 8'h04), 16'h0000);
    @(posedge clk_sys);
    cfg_req <= 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(16'(cfg_grant), 16'h0000);
    @(posedge clk_sys);
    prog_mode <= 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(16'(cfg_grant), 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
